// file: rtl/status_filter_defines.vh
// constants for the operation status transition filter
`ifndef STATUS_FILTER_DEFINES_VH
`define STATUS_FILTER_DEFINES_VH
`define REG_W              16
`define OPERATION_SUMMARY_BIT_DEFINED_W     7
`define QUES_DEFINED_W     13
`define SEL_COND           3'h0
`define SEL_EVENT          3'h1
`define SEL_ENABLE         3'h2
`define SEL_FALL           3'h3
`define SEL_RISE           3'h4
`define SEL_QFALL          3'h5
`define SEL_QRISE          3'h6
`define SEL_QENABLE        3'h7
`define OPERATION_SUMMARY_BIT_FALL_RESET    16'h0000
`define OPERATION_SUMMARY_BIT_RISE_RESET    16'h007F
`define OPERATION_SUMMARY_BIT_ENABLE_RESET  16'h0000
`define QUES_FALL_RESET    16'h0000
`define QUES_RISE_RESET    16'h1FFF
`define QUES_ENABLE_RESET  16'h0000
`define BIT_CONST_VOLTAGE  0
`define BIT_CONST_CURRENT  1
`define BIT_OUTPUT_OFF     2
`define BIT_MEAS_WAIT      3
`define BIT_TRAN_WAIT      4
`define BIT_MEAS_ACTIVE    5
`define BIT_TRAN_ACTIVE    6
`define SUMMARY_BIT        7
`endif

// file: rtl/status_transition_filter.v
// per-channel operation status condition, transition filter, event and enable registers
`include "status_filter_defines.vh"

// Overview of operation
// [R01] falling-edge mask bit set: a 1-to-0 condition change sets the event bit
// [R02] rising-edge mask bit set: a 0-to-1 condition change sets the event bit
// [R03] both mask bits set: either direction of change sets the event bit
// [R04] both mask bits clear: that event bit is never set by transitions
// [R05] condition bits: 0 constant voltage, 1 constant current, 2 output off
// [R06] bits 3/4 meas/transient wait trigger, bits 5/6 meas/transient initiated
// [R07] unused bits 7 to 15 always read back as zero
// [R08] both mask registers are writable and read back as weighted values
// [R09] a mask read returns the binary-weighted sum of set bits
// [R10] each access names one or more channels; writes go to every listed channel
// [R11] preset clears every falling-edge mask bit
// [R12] preset sets rising-edge mask to all defined bits, value 127
// [R13] preset clears enables, sets questionable rise mask 8191, clears its fall mask
// [R14] event bits stay set until event read or clear-status command
// [R15] summary bit 7 is the OR of enabled event bits
// [R16] edges compare with last cycle's condition; edge set wins over read-clear
module status_transition_filter #(
    parameter CHANNELS = 4
) (
    input  wire                        clk,
    input  wire                        reset,
    input  wire                        clk_en,
    input  wire [CHANNELS*7-1:0]       operation_summary_bit_cond_in,
    input  wire                        acc_valid,
    input  wire                        acc_write,
    input  wire [2:0]                  acc_sel,
    input  wire [CHANNELS-1:0]         acc_chan,
    input  wire [15:0]                 acc_wdata,
    input  wire                        preset_cmd,
    input  wire                        clear_status_cmd,
    output reg  [15:0]                 acc_rdata,
    output reg                         acc_rvalid,
    output reg  [CHANNELS-1:0]         operation_summary_bit
);
    localparam DW = `OPERATION_SUMMARY_BIT_DEFINED_W;
    localparam QW = `QUES_DEFINED_W;

    // full-width reset and preset words, sliced to the defined width where used,
    // so the constants stay sixteen bits like the registers they describe
    localparam [15:0] FALL_WORD    = `OPERATION_SUMMARY_BIT_FALL_RESET;
    localparam [15:0] RISE_WORD    = `OPERATION_SUMMARY_BIT_RISE_RESET;
    localparam [15:0] ENABLE_WORD  = `OPERATION_SUMMARY_BIT_ENABLE_RESET;
    localparam [15:0] QFALL_WORD   = `QUES_FALL_RESET;
    localparam [15:0] QRISE_WORD   = `QUES_RISE_RESET;
    localparam [15:0] QENABLE_WORD = `QUES_ENABLE_RESET;

    // per-channel summary, collected here so one process owns the output flops
    wire [CHANNELS-1:0] nxt_summary;

    // lowest listed channel answers a read; one value per reply
    // searching from the top down leaves the lowest listed channel selected
    reg [CHANNELS-1:0] rd_onehot;
    integer k;
    always @* begin
        rd_onehot = {CHANNELS{1'b0}};
        for (k = CHANNELS - 1; k >= 0; k = k - 1) begin
            if (acc_chan[k]) begin
                rd_onehot = {CHANNELS{1'b0}};
                rd_onehot[k] = 1'b1;
            end
        end
    end

    wire [CHANNELS*16-1:0] rd_flat;

    genvar g;
    generate
        for (g = 0; g < CHANNELS; g = g + 1) begin : chan
            // named condition flags; each sits at the weight of its register bit
            wire const_voltage_flag     = operation_summary_bit_cond_in[g*DW + `BIT_CONST_VOLTAGE]; // R05
            wire const_current_flag     = operation_summary_bit_cond_in[g*DW + `BIT_CONST_CURRENT]; // R05
            wire output_off_flag        = operation_summary_bit_cond_in[g*DW + `BIT_OUTPUT_OFF];    // R05
            wire meas_trigger_wait      = operation_summary_bit_cond_in[g*DW + `BIT_MEAS_WAIT];     // R06
            wire transient_trigger_wait = operation_summary_bit_cond_in[g*DW + `BIT_TRAN_WAIT];     // R06
            wire meas_active_flag       = operation_summary_bit_cond_in[g*DW + `BIT_MEAS_ACTIVE];   // R06
            wire transient_active_flag  = operation_summary_bit_cond_in[g*DW + `BIT_TRAN_ACTIVE];   // R06

            // live condition word, rebuilt from the flags at their bit positions
            wire [DW-1:0] cond;
            assign cond[`BIT_CONST_VOLTAGE] = const_voltage_flag;
            assign cond[`BIT_CONST_CURRENT] = const_current_flag;
            assign cond[`BIT_OUTPUT_OFF]    = output_off_flag;
            assign cond[`BIT_MEAS_WAIT]     = meas_trigger_wait;
            assign cond[`BIT_TRAN_WAIT]     = transient_trigger_wait;
            assign cond[`BIT_MEAS_ACTIVE]   = meas_active_flag;
            assign cond[`BIT_TRAN_ACTIVE]   = transient_active_flag;

            // operation group state: last condition, masks, events, enables
            reg  [DW-1:0] cond_prev_ff;
            reg  [DW-1:0] fall_ff;
            reg  [DW-1:0] rise_ff;
            reg  [DW-1:0] event_ff;
            reg  [DW-1:0] enable_ff;

            // questionable group registers; only reset, preset and writes touch them here
            reg  [QW-1:0] qfall_ff;
            reg  [QW-1:0] qrise_ff;
            reg  [QW-1:0] qenable_ff;

            // readback word and access decode for this channel
            reg  [15:0]   rd_val;
            wire          sel_ch = acc_valid & acc_chan[g]; // R10
            wire          wr     = sel_ch & acc_write;
            wire          rd_evt = acc_valid & ~acc_write & rd_onehot[g]
                                   & (acc_sel == `SEL_EVENT);
            // direction of change against last cycle's registered condition
            wire [DW-1:0] went_low  = cond_prev_ff & ~cond;  // R16
            wire [DW-1:0] went_high = ~cond_prev_ff & cond;  // R16

            // edge sets: masks decide which direction latches
            wire [DW-1:0] edge_set = (went_low & fall_ff)    // R01 R03 R04
                                   | (went_high & rise_ff);  // R02 R03 R04

            // event next value; a fresh edge survives a read or clear-status,
            // so a transition landing on the clearing cycle is never lost
            reg  [DW-1:0] nxt_event;
            always @* begin
                nxt_event = event_ff | edge_set;          // R14
                if (rd_evt | clear_status_cmd)
                    nxt_event = edge_set;                 // R14 R16
            end

            // summary of enabled events, registered with the other outputs
            assign nxt_summary[g] = |(event_ff & enable_ff); // R15

            // readback, zero-extended so unused bits read zero
            always @* begin
                case (acc_sel)
                    `SEL_COND:    rd_val = {9'h000, cond};
                    `SEL_EVENT:   rd_val = {9'h000, event_ff};
                    `SEL_ENABLE:  rd_val = {9'h000, enable_ff};
                    `SEL_FALL:    rd_val = {9'h000, fall_ff};   // R08 R09 R07
                    `SEL_RISE:    rd_val = {9'h000, rise_ff};   // R08 R09 R07
                    `SEL_QFALL:   rd_val = {3'h0, qfall_ff};
                    `SEL_QRISE:   rd_val = {3'h0, qrise_ff};
                    `SEL_QENABLE: rd_val = {3'h0, qenable_ff};
                    default:      rd_val = 16'h0000;
                endcase
            end
            assign rd_flat[g*16 +: 16] = rd_val;

            // masks: preset overrides a same-cycle write
            // a write landing with a preset is dropped; the preset is the stronger action
            always @(posedge clk or posedge reset) begin
                if (reset) begin
                    fall_ff    <= FALL_WORD[DW-1:0];
                    rise_ff    <= RISE_WORD[DW-1:0];
                    enable_ff  <= ENABLE_WORD[DW-1:0];
                    qfall_ff   <= QFALL_WORD[QW-1:0];
                    qrise_ff   <= QRISE_WORD[QW-1:0];
                    qenable_ff <= QENABLE_WORD[QW-1:0];
                end else if (clk_en) begin
                    if (preset_cmd) begin
                        fall_ff    <= FALL_WORD[DW-1:0];    // R11
                        rise_ff    <= RISE_WORD[DW-1:0];    // R12
                        enable_ff  <= ENABLE_WORD[DW-1:0];  // R13
                        qfall_ff   <= QFALL_WORD[QW-1:0];   // R13
                        qrise_ff   <= QRISE_WORD[QW-1:0];   // R13
                        qenable_ff <= QENABLE_WORD[QW-1:0]; // R13
                    end else if (wr) begin
                        // bits above the defined width are dropped on write
                        case (acc_sel)
                            `SEL_FALL:    fall_ff    <= acc_wdata[DW-1:0]; // R08 R10
                            `SEL_RISE:    rise_ff    <= acc_wdata[DW-1:0]; // R08 R10
                            `SEL_ENABLE:  enable_ff  <= acc_wdata[DW-1:0];
                            `SEL_QFALL:   qfall_ff   <= acc_wdata[QW-1:0];
                            `SEL_QRISE:   qrise_ff   <= acc_wdata[QW-1:0];
                            `SEL_QENABLE: qenable_ff <= acc_wdata[QW-1:0];
                            // condition and event are read-only: writes fall through
                            default:      fall_ff    <= fall_ff;
                        endcase
                    end
                end
            end

            // last-cycle condition and sticky event flops
            // clear-status reaches every channel at once; a read clears only this one
            always @(posedge clk or posedge reset) begin
                if (reset) begin
                    cond_prev_ff <= {DW{1'b0}};
                    event_ff     <= {DW{1'b0}};
                end else if (clk_en) begin
                    cond_prev_ff <= cond;      // R16
                    event_ff     <= nxt_event; // R14
                end
            end
        end
    endgenerate

    // read reply registered; one cycle after the request
    reg [15:0] rd_mux;
    integer j;
    always @* begin
        rd_mux = 16'h0000;
        for (j = 0; j < CHANNELS; j = j + 1) begin
            if (rd_onehot[j])
                rd_mux = rd_flat[j*16 +: 16];
        end
    end

    // a read that names at least one channel earns an answer; an empty list
    // still loads zero into rdata but raises no valid
    wire rd_req   = acc_valid & ~acc_write;
    wire rd_named = rd_req & (|acc_chan);

    // every output of the block leaves one of these flops
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            acc_rdata             <= 16'h0000;
            acc_rvalid            <= 1'b0;
            operation_summary_bit <= {CHANNELS{1'b0}};
        end else if (clk_en) begin
            acc_rvalid            <= rd_named;
            operation_summary_bit <= nxt_summary; // R15
            if (rd_req)
                acc_rdata <= rd_mux; // R09
        end
    end
endmodule

// file: tb/status_filter_chk.sv
// port assertions for the status transition filter
module status_filter_chk #(parameter CHANNELS = 4) (
    input wire logic                  clk,
    input wire logic                  reset,
    input wire logic                  clk_en,
    input wire logic [CHANNELS*7-1:0] operation_summary_bit_cond_in,
    input wire logic                  acc_valid,
    input wire logic                  acc_write,
    input wire logic [2:0]            acc_sel,
    input wire logic [CHANNELS-1:0]   acc_chan,
    input wire logic                  preset_cmd,
    input wire logic                  clear_status_cmd,
    input wire logic [15:0]           acc_rdata,
    input wire logic                  acc_rvalid,
    input wire logic [CHANNELS-1:0]   operation_summary_bit
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // a read naming a channel, taken on an enabled edge
    wire rd = clk_en && acc_valid && !acc_write && |acc_chan;
    // a read right after a preset sees the preset value, no later write can hide it
    property p_pre(logic [2:0] s, logic [15:0] v);
        preset_cmd && clk_en ##1 rd && acc_sel == s |=> acc_rdata == v;
    endproperty
    a_read_answer: assert property (rd |=> acc_rvalid) else $error("read unanswered");
    a_answer_cause: assert property ($past(clk_en) && acc_rvalid |-> $past(rd))
        else $error("answer without read");
    a_operation_summary_bit_unused: assert property ($past(clk_en) && acc_rvalid && $past(acc_sel) < 3'h5 |->
        acc_rdata[15:7] == 9'h000) else $error("operation_summary_bit unused bits set");
    a_ques_unused: assert property (acc_rvalid |-> acc_rdata[15:13] == 3'h0)
        else $error("ques unused bits set");
    a_pre_fall: assert property (p_pre(3'h3, 16'h0000)) else $error("fall preset");
    a_pre_rise: assert property (p_pre(3'h4, 16'h007F)) else $error("rise preset");
    a_pre_ques: assert property (p_pre(3'h6, 16'h1FFF)) else $error("ques preset");
    a_pre_enable: assert property (p_pre(3'h2, 16'h0000)) else $error("enable preset");
    a_clear_quiet: assert property (clear_status_cmd && clk_en && $stable(operation_summary_bit_cond_in)
        |-> ##2 operation_summary_bit == '0) else $error("summary after clear");
    c_read: cover property (rd);
    c_preset_read: cover property (preset_cmd ##1 rd);
    c_summary: cover property ($rose(operation_summary_bit[0]));
endmodule
bind status_transition_filter status_filter_chk #(.CHANNELS(CHANNELS)) chk (.*);

// file: tb/status_host_model.sv
// host model issuing register accesses and status commands
module status_host_model (
    input  wire logic        clk,
    input  wire logic [15:0] acc_rdata,
    input  wire logic        acc_rvalid,
    output logic             acc_valid = 1'b0,
    output logic             acc_write = 1'b0,
    output logic [2:0]       acc_sel = 3'h0,
    output logic [3:0]       acc_chan = 4'h0,
    output logic [15:0]      acc_wdata = 16'h0000,
    output logic             preset_cmd = 1'b0,
    output logic             clear_status_cmd = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    // one access a call; idle write data is inverted so stale data never looks valid
    task automatic access(input logic w, input logic [2:0] s, input logic [3:0] ch,
                          input logic [15:0] wd, output logic [15:0] rd);
        @(negedge clk);
        {acc_valid, acc_write, acc_sel, acc_chan, acc_wdata} = {1'b1, w, s, ch, wd};
        {preset_cmd, clear_status_cmd} = 2'b00;
        @(negedge clk);
        rd = acc_rvalid ? acc_rdata : 16'hXXXX;
        {acc_valid, acc_wdata} = {1'b0, ~wd};
    endtask
    // command pulse; the following access lowers it after one cycle
    task automatic cmd(input logic p, input logic c);
        @(negedge clk);
        {preset_cmd, clear_status_cmd} = {p, c};
    endtask
endmodule

// file: tb/status_transition_filter_tb.sv
// self-checking bench for the status transition filter
module status_transition_filter_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, reset = 1'b1, clk_en = 1'b1;
    logic [27:0] operation_summary_bit_cond_in = 28'h0000000;
    logic        acc_valid, acc_write, acc_rvalid, preset_cmd, clear_status_cmd;
    logic [2:0]  acc_sel;
    logic [3:0]  acc_chan, operation_summary_bit;
    logic [15:0] acc_wdata, acc_rdata, rd;
    logic [15:0] dval [6] = '{16'h0000, 16'h0000, 16'h007F, 16'h0000, 16'h1FFF, 16'h0000};
    int          bad_count = 0, checked = 0;
    status_transition_filter DUT (.*);
    status_host_model host (.*);
    always #2.5 clk = ~clk;
    // shared compare, read and write helpers
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd_chk(input logic [2:0] s, input logic [3:0] ch, input logic [15:0] exp);
        host.access(1'b0, s, ch, 16'h0000, rd);
        check($sformatf("sel %0d chan %b", s, ch), exp, rd);
    endtask
    task automatic wr(input logic [2:0] s, input logic [3:0] ch, input logic [15:0] v);
        host.access(1'b1, s, ch, v, rd);
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // hang guard, far beyond the roughly 120 cycles the sequence needs
    initial begin
        #20us;
        bad_count++;
        report_and_stop();
    end
    // main sequence: defaults, preset, masks, condition map, edge filter, clear
    initial begin
        repeat (16) @(posedge clk);
        @(negedge clk) reset = 1'b0;
        for (int i = 0; i < 6; i++) rd_chk(3'(i + 2), 4'h1, dval[i]);
        for (int i = 0; i < 6; i++) begin
            wr(3'(i + 2), 4'h1, 16'h1555);
            host.cmd(1'b1, 1'b0);
            rd_chk(3'(i + 2), 4'h1, dval[i]);
        end
        for (int b = 0; b < 7; b++) begin
            @(negedge clk) operation_summary_bit_cond_in = 28'h0000001 << b;
            rd_chk(3'h0, 4'h1, 16'h0001 << b);
        end
        @(negedge clk) operation_summary_bit_cond_in = 28'h0000000;
        rd_chk(3'h1, 4'h1, 16'h007F);
        rd_chk(3'h1, 4'h1, 16'h0000);
        wr(3'h3, 4'h5, 16'hFF89);
        rd_chk(3'h3, 4'h4, 16'h0009);
        rd_chk(3'h3, 4'h2, 16'h0000);
        rd_chk(3'h3, 4'hC, 16'h0009);
        wr(3'h4, 4'h1, 16'h000A);
        rd_chk(3'h4, 4'h1, 16'h000A);
        // frozen clock enable: a write in that window must not land
        @(negedge clk) clk_en = 1'b0;
        wr(3'h4, 4'h1, 16'h0001);
        @(negedge clk) clk_en = 1'b1;
        rd_chk(3'h4, 4'h1, 16'h000A);
        wr(3'h2, 4'h1, 16'h007F);
        // rises on bits 0-3: only rise-masked bits latch, bit 2 never does
        @(negedge clk) operation_summary_bit_cond_in = 28'h000000F;
        repeat (2) @(negedge clk);
        check("summary", 16'h0001, {15'h0000, operation_summary_bit[0]});
        rd_chk(3'h1, 4'h1, 16'h000A);
        @(negedge clk) operation_summary_bit_cond_in = 28'h0000000;
        rd_chk(3'h1, 4'h1, 16'h0009);
        @(negedge clk) operation_summary_bit_cond_in = 28'h000000F;
        host.cmd(1'b0, 1'b1);
        rd_chk(3'h1, 4'h1, 16'h0000);
        // an edge on the clearing cycle stays latched
        fork
            host.cmd(1'b0, 1'b1);
            @(negedge clk) operation_summary_bit_cond_in = 28'h0000000;
        join
        rd_chk(3'h1, 4'h1, 16'h0009);
        report_and_stop();
    end
endmodule
